//--- uhdpc_pkg.sv
/*
 * Shared constants and types for the hub downstream port controller:
 * register indices, command codes, status field positions, timing.
 * Assumes a single 125 MHz clock; register indices are word indices
 * on an AHB-Lite bus (byte address = index * 4).
 */
`default_nettype none

package uhdpc_pkg;

    // ==================================================================
    // register map (word indices)
    localparam logic [9:0] UHDPC_IDX_COMMAND = 10'h0d6;
    localparam logic [9:0] UHDPC_IDX_STATUS  = 10'h0d7;
    localparam logic [9:0] UHDPC_IDX_SELECT  = 10'h0d8;
    localparam logic [9:0] UHDPC_IDX_POWER   = 10'h0d9;

    localparam logic [7:0] UHDPC_SELECT_RST  = 8'h00;
    localparam logic [5:2] UHDPC_POWER_RST   = 4'h0;
    localparam logic [7:0] UHDPC_STATUS_RST  = 8'h00;

    // ==================================================================
    // port commands
    localparam logic [2:0] UHDPC_CMD_DISABLE = 3'h0;
    localparam logic [2:0] UHDPC_CMD_ENABLE  = 3'h1;
    localparam logic [2:0] UHDPC_CMD_RESET   = 3'h2;
    localparam logic [2:0] UHDPC_CMD_SUSPEND = 3'h3;
    localparam logic [2:0] UHDPC_CMD_RESUME  = 3'h4;

    // ==================================================================
    // status field positions
    localparam int UHDPC_ST_DPLUS   = 7;
    localparam int UHDPC_ST_DMINUS  = 6;
    localparam int UHDPC_ST_SLOW    = 5;
    localparam int UHDPC_ST_POWERED = 4;
    localparam int UHDPC_ST_RESET   = 3;
    localparam int UHDPC_ST_SUSPEND = 2;
    localparam int UHDPC_ST_ENABLED = 1;
    localparam int UHDPC_ST_CONNECT = 0;

    // ==================================================================
    // timing
    localparam int UHDPC_CLK_KHZ      = 125000;
    localparam int UHDPC_RESET_MS     = 15;
    localparam int UHDPC_RESUME_MS    = 20;
    localparam int UHDPC_EOP_SE0_NS   = 1334;
    localparam int UHDPC_EOP_J_NS     = 667;
    localparam int UHDPC_RESET_CYC    = UHDPC_RESET_MS * UHDPC_CLK_KHZ;
    localparam int UHDPC_RESUME_CYC   = UHDPC_RESUME_MS * UHDPC_CLK_KHZ;
    localparam int UHDPC_EOP_SE0_CYC  =
        (UHDPC_EOP_SE0_NS * (UHDPC_CLK_KHZ / 1000) + 999) / 1000;
    localparam int UHDPC_EOP_J_CYC    =
        (UHDPC_EOP_J_NS * (UHDPC_CLK_KHZ / 1000) + 999) / 1000;
    localparam int UHDPC_CNT_W        = 22;

    typedef enum logic [2:0] {
        UHDPC_PH_IDLE,
        UHDPC_PH_RESET,
        UHDPC_PH_RESUME,
        UHDPC_PH_EOP_SE0,
        UHDPC_PH_EOP_J
    } uhdpc_phase_t;

    typedef enum logic [1:0] {
        UHDPC_PD_NONE,
        UHDPC_PD_DISABLE,
        UHDPC_PD_ENABLE,
        UHDPC_PD_SUSPEND
    } uhdpc_pend_t;

endpackage

`default_nettype wire

//--- uhdpc_port_ctrl.sv
/*
 * Downstream port control for a five-port USB hub: port 1 is the
 * embedded function, ports 2..5 are external. Registers on AHB-Lite.
 * Assumes eof_sample_i and bus_idle_i come from the hub repeater on
 * the same clock; line pins are asynchronous and are synchronised.
 */
// Design decision made here: the AHB-Lite interface to the registers.
// How it works
// RULE_01 - root port 0 unselectable; port 1 embedded; ports 2..5 external.
// RULE_02 - one command register acts on the port named by the index.
// RULE_03 - power on only from off; power off ignored when already off.
// RULE_04 - enable only when disabled; disable only when enabled.
// RULE_05 - reset needs power and connection; suspend needs enabled; resume suspended.
// RULE_06 - firmware reads status first and stalls requests hardware would ignore.
// RULE_07 - code 000 disables, 001 enables, both at next bus idle.
// RULE_08 - external reset: SE0 at once for 15 ms, then enabled.
// RULE_09 - port 1 reset: pulse function reset, enable after 15 ms.
// RULE_10 - firmware finishes embedded-function reset within 15 ms.
// RULE_11 - external suspend: J at next idle, traffic forwarding stops.
// RULE_12 - port 1 suspend at next idle stops its traffic.
// RULE_13 - external resume: K 20 ms, low-speed EOP, then enabled.
// RULE_14 - port 1 resume: enabled again after 20 ms.
// RULE_15 - commanded changes reach status only at end-of-frame sample.
// RULE_16 - status register is read-only; writes do nothing.
// RULE_17 - bits 7,6 line values at sample; port 1 reads 1 and 0.
// RULE_18 - bit 5 low-speed attached at sample; port 1 reads 0.
// RULE_19 - bit 4 power after over-current, at sample; port 1 reads 1.
// RULE_20 - bit 3 set while commanded reset runs, sampled at end-of-frame.
// RULE_21 - bits 2,1 suspended and enabled, sampled at end-of-frame.
// RULE_22 - bit 0 connect sampled at end-of-frame; port 1 reads 1.
// RULE_23 - index low two bits choose port in binary; root not selectable.
`timescale 1ns/1ns
`default_nettype none

module uhdpc_port_ctrl
    import uhdpc_pkg::*;
#(
    parameter int RESET_CYCLES  = UHDPC_RESET_CYC,
    parameter int RESUME_CYCLES = UHDPC_RESUME_CYC
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // repeater timing
    input  wire logic        eof_sample_i,
    input  wire logic        bus_idle_i,
    // external port pins
    input  wire logic [5:2]  dplus_i,
    input  wire logic [5:2]  dminus_i,
    input  wire logic        overcurrent_i,
    output logic      [5:2]  dplus_o,
    output logic      [5:2]  dminus_o,
    output logic      [5:2]  line_oe_o,
    output logic      [5:2]  port_power_o,
    // traffic gating and embedded function
    output logic      [5:1]  forward_en_o,
    output logic             function_reset_o,
    output logic             function_suspend_o
);

    // ==================================================================
    // helpers

    // two index bits pick ports 1..4; bit 2 reaches port 5
    function automatic logic [2:0] uhdpc_port_of(input logic [7:0] idx);
        logic [2:0] p;
        p = 3'(idx[1:0]) + 3'h1;
        if (idx[2])
            p = 3'h5;
        return p;
    endfunction

    // ==================================================================
    // pin synchronisers
    logic [5:2] dp_m;
    logic [5:2] dp_s;
    logic [5:2] dm_m;
    logic [5:2] dm_s;
    logic       oc_m;
    logic       oc_s;

    always_ff @(posedge clk_i)
    begin
        dp_m <= dplus_i;
        dp_s <= dp_m;
        dm_m <= dminus_i;
        dm_s <= dm_m;
        oc_m <= overcurrent_i;
        oc_s <= oc_m;
    end

    // ==================================================================
    // bus slave
    logic        wr_pend;
    logic [9:0]  wr_idx;
    logic [7:0]  port_select_index;
    logic [5:2]  port_power_control;
    logic        cmd_wr;
    logic [2:0]  cmd_code;
    logic [7:0]  stat_q [5:1];

    wire logic       bus_req   = hsel_i && htrans_i[1] && hready_i;
    wire logic [9:0] req_idx   = haddr_i[11:2];
    wire logic       req_map   = haddr_i[31:12] == 20'h00000;
    wire logic [2:0] sel_port  = uhdpc_port_of(port_select_index); // RULE_23
    wire logic [2:0] rd_port   = uhdpc_port_of(port_select_index);
    wire logic       wr_cmd    = wr_pend && wr_idx == UHDPC_IDX_COMMAND;
    wire logic       wr_sel    = wr_pend && wr_idx == UHDPC_IDX_SELECT;
    wire logic       wr_pwr    = wr_pend && wr_idx == UHDPC_IDX_POWER;
    wire logic [7:0] stat_sel  = stat_q[rd_port];
    wire logic [31:0] rd_word  =
        !req_map                    ? 32'h0 :
        req_idx == UHDPC_IDX_STATUS ? {24'h0, stat_sel} :
        req_idx == UHDPC_IDX_SELECT ? {24'h0, port_select_index} :
        req_idx == UHDPC_IDX_POWER  ? {26'h0, port_power_control, 2'h0} :
                                      32'h0;
    // power bits act only in the direction that changes them
    wire logic [5:2] next_power = hwdata_i[5:2]; // RULE_03

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_pend            <= 1'b0;
            wr_idx             <= 10'h0;
            hrdata_o           <= 32'h0;
            hreadyout_o        <= 1'b1;
            hresp_o            <= 1'b0;
            port_select_index  <= UHDPC_SELECT_RST;
            port_power_control <= UHDPC_POWER_RST;
            cmd_wr             <= 1'b0;
            cmd_code           <= UHDPC_CMD_DISABLE;
        end
        else
        begin
            wr_pend     <= bus_req && hwrite_i && req_map;
            wr_idx      <= req_idx;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (bus_req && !hwrite_i)
                hrdata_o <= rd_word;
            // status index has no write path at all
            cmd_wr   <= wr_cmd; // RULE_16
            cmd_code <= hwdata_i[2:0];
            if (wr_sel)
                port_select_index <= hwdata_i[7:0];
            if (wr_pwr)
                port_power_control <= next_power;
        end
    end

    // ==================================================================
    // per-port state
    uhdpc_phase_t ph      [5:1];
    uhdpc_pend_t  pend    [5:1];
    logic         en      [5:1];
    logic         sus     [5:1];
    logic         jdrv    [5:1];
    logic         conn_q  [5:1];
    logic         pwr     [5:1];
    logic [UHDPC_CNT_W-1:0] cnt [5:1];

    for (genvar p = 1; p <= 5; p++)
    begin : g_port
        localparam bit EXT = (p != 1); // RULE_01

        wire logic hit      = cmd_wr && sel_port == 3'(p); // RULE_02
        wire logic disabled = conn_q[p] && !en[p];
        wire logic active   = en[p] && !sus[p];

        if (EXT)
        begin : g_pwr
            assign pwr[p] = port_power_control[p] && !oc_s; // RULE_19
        end
        else
        begin : g_pwr1
            assign pwr[p] = 1'b1;
        end

        always_ff @(posedge clk_i)
        begin
            // power loss or disconnect drops the port to its base state
            if (rst_i || !pwr[p] || !conn_q[p])
            begin
                ph[p]   <= UHDPC_PH_IDLE;
                pend[p] <= UHDPC_PD_NONE;
                en[p]   <= 1'b0;
                sus[p]  <= 1'b0;
                jdrv[p] <= 1'b0;
                cnt[p]  <= '0;
            end
            else
            begin
                jdrv[p] <= 1'b0;
                if (cnt[p] != '0)
                    cnt[p] <= cnt[p] - 1'b1;
                case (ph[p])
                    UHDPC_PH_IDLE:
                    begin
                        if (hit)
                        begin
                            case (cmd_code)
                                UHDPC_CMD_DISABLE:
                                    if (active)
                                        pend[p] <= UHDPC_PD_DISABLE; // RULE_04
                                UHDPC_CMD_ENABLE:
                                    if (disabled)
                                        pend[p] <= UHDPC_PD_ENABLE; // RULE_04
                                UHDPC_CMD_RESET:
                                begin
                                    // power and connection already hold here
                                    ph[p]   <= UHDPC_PH_RESET; // RULE_05
                                    pend[p] <= UHDPC_PD_NONE;
                                    en[p]   <= 1'b0;
                                    sus[p]  <= 1'b0;
                                    cnt[p]  <= UHDPC_CNT_W'(RESET_CYCLES - 1);
                                end
                                UHDPC_CMD_SUSPEND:
                                    if (active)
                                        pend[p] <= UHDPC_PD_SUSPEND; // RULE_05
                                UHDPC_CMD_RESUME:
                                    if (sus[p])
                                    begin
                                        ph[p]  <= UHDPC_PH_RESUME; // RULE_05
                                        cnt[p] <=
                                            UHDPC_CNT_W'(RESUME_CYCLES - 1);
                                    end
                                default:
                                    pend[p] <= pend[p];
                            endcase
                        end
                        else if (bus_idle_i)
                        begin
                            // applied only between packets
                            case (pend[p])
                                UHDPC_PD_DISABLE:
                                    en[p] <= 1'b0; // RULE_07
                                UHDPC_PD_ENABLE:
                                    en[p] <= 1'b1; // RULE_07
                                UHDPC_PD_SUSPEND:
                                begin
                                    sus[p]  <= 1'b1; // RULE_11 RULE_12
                                    jdrv[p] <= EXT;
                                end
                                default:
                                    en[p] <= en[p];
                            endcase
                            pend[p] <= UHDPC_PD_NONE;
                        end
                    end
                    UHDPC_PH_RESET:
                        if (cnt[p] == '0)
                        begin
                            ph[p] <= UHDPC_PH_IDLE;
                            en[p] <= 1'b1; // RULE_08 RULE_09
                        end
                    UHDPC_PH_RESUME:
                        if (cnt[p] == '0)
                        begin
                            if (EXT)
                            begin
                                ph[p]  <= UHDPC_PH_EOP_SE0; // RULE_13
                                cnt[p] <=
                                    UHDPC_CNT_W'(UHDPC_EOP_SE0_CYC - 1);
                            end
                            else
                            begin
                                ph[p]  <= UHDPC_PH_IDLE;
                                sus[p] <= 1'b0; // RULE_14
                            end
                        end
                    UHDPC_PH_EOP_SE0:
                        if (cnt[p] == '0)
                        begin
                            ph[p]  <= UHDPC_PH_EOP_J;
                            cnt[p] <= UHDPC_CNT_W'(UHDPC_EOP_J_CYC - 1);
                        end
                    UHDPC_PH_EOP_J:
                        if (cnt[p] == '0)
                        begin
                            ph[p]  <= UHDPC_PH_IDLE;
                            sus[p] <= 1'b0; // RULE_13
                        end
                    default:
                        ph[p] <= UHDPC_PH_IDLE;
                endcase
            end
        end
    end

    // ==================================================================
    // line drive and end-of-frame sampling
    logic [5:2] drv_dp;
    logic [5:2] drv_dm;
    logic [5:2] drv_oe;

    always_comb
    begin
        for (int p = 2; p <= 5; p++)
        begin
            drv_dp[p] = 1'b0;
            drv_dm[p] = 1'b0;
            drv_oe[p] = 1'b1;
            case (ph[p])
                UHDPC_PH_RESET:   drv_oe[p] = 1'b1;   // RULE_08
                UHDPC_PH_RESUME:  drv_dm[p] = 1'b1;   // RULE_13
                UHDPC_PH_EOP_SE0: drv_oe[p] = 1'b1;   // RULE_13
                UHDPC_PH_EOP_J:   drv_dp[p] = 1'b1;   // RULE_13
                default:
                begin
                    drv_dp[p] = jdrv[p];              // RULE_11
                    drv_oe[p] = jdrv[p];
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dplus_o            <= 4'h0;
            dminus_o           <= 4'h0;
            line_oe_o          <= 4'h0;
            port_power_o       <= 4'h0;
            forward_en_o       <= 5'h00;
            function_reset_o   <= 1'b0;
            function_suspend_o <= 1'b0;
            conn_q[1]          <= 1'b1;
            stat_q[1]          <= UHDPC_STATUS_RST;
            for (int p = 2; p <= 5; p++)
            begin
                conn_q[p] <= 1'b0;
                stat_q[p] <= UHDPC_STATUS_RST;
            end
        end
        else
        begin
            dplus_o   <= drv_dp;
            dminus_o  <= drv_dm;
            line_oe_o <= drv_oe;
            for (int p = 2; p <= 5; p++)
                port_power_o[p] <= pwr[p];
            for (int p = 1; p <= 5; p++)
                forward_en_o[p] <= en[p] && !sus[p]
                                   && ph[p] == UHDPC_PH_IDLE; // RULE_11
            function_reset_o   <= cmd_wr && sel_port == 3'h1
                                  && cmd_code == UHDPC_CMD_RESET; // RULE_09
            function_suspend_o <= sus[1]; // RULE_12
            conn_q[1] <= 1'b1;
            if (eof_sample_i)
            begin
                // own drive would mask the device, so keep last view
                for (int p = 2; p <= 5; p++)
                    if (!drv_oe[p])
                        conn_q[p] <= pwr[p] && (dp_s[p] || dm_s[p]); // RULE_22
                stat_q[1][UHDPC_ST_DPLUS]   <= 1'b1;            // RULE_17
                stat_q[1][UHDPC_ST_DMINUS]  <= 1'b0;            // RULE_17
                stat_q[1][UHDPC_ST_SLOW]    <= 1'b0;            // RULE_18
                stat_q[1][UHDPC_ST_POWERED] <= 1'b1;            // RULE_19
                stat_q[1][UHDPC_ST_CONNECT] <= 1'b1;            // RULE_22
                for (int p = 2; p <= 5; p++)
                begin
                    stat_q[p][UHDPC_ST_DPLUS]   <= dp_s[p];     // RULE_17
                    stat_q[p][UHDPC_ST_DMINUS]  <= dm_s[p];     // RULE_17
                    stat_q[p][UHDPC_ST_SLOW]    <= dm_s[p] && !dp_s[p]; // RULE_18
                    stat_q[p][UHDPC_ST_POWERED] <= pwr[p];      // RULE_19
                    stat_q[p][UHDPC_ST_CONNECT] <= drv_oe[p] ? conn_q[p]
                        : pwr[p] && (dp_s[p] || dm_s[p]);       // RULE_22
                end
                for (int p = 1; p <= 5; p++)
                begin
                    stat_q[p][UHDPC_ST_RESET]   <=
                        ph[p] == UHDPC_PH_RESET;                // RULE_20
                    stat_q[p][UHDPC_ST_SUSPEND] <= sus[p];      // RULE_21
                    stat_q[p][UHDPC_ST_ENABLED] <= en[p];       // RULE_15 RULE_21
                end
            end
        end
    end

endmodule // uhdpc_port_ctrl

`default_nettype wire

//--- uhdpc_checker.sv
/* Checker for uhdpc_port_ctrl: line signalling and traffic gating.
   Bound to the controller; port 2 stands for every external port. */
`timescale 1ns/1ns
`default_nettype none
module uhdpc_checker
#(
    parameter int RESET_CYCLES  = 50,
    parameter int RESUME_CYCLES = 60
)
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       overcurrent_i,
    input wire logic [5:2] dplus_o,
    input wire logic [5:2] dminus_o,
    input wire logic [5:2] line_oe_o,
    input wire logic [5:2] port_power_o,
    input wire logic [5:1] forward_en_o,
    input wire logic       function_reset_o,
    input wire logic       function_suspend_o
);
    logic se0;
    logic kst;
    int   se0_cnt;
    int   k_cnt;
    assign se0 = line_oe_o[2] & ~dplus_o[2] & ~dminus_o[2];
    assign kst = line_oe_o[2] & ~dplus_o[2] & dminus_o[2];
    always_ff @(posedge clk_i)
    begin
        se0_cnt <= (rst_i || !se0) ? 0 : se0_cnt + 1;
        k_cnt   <= (rst_i || !kst) ? 0 : k_cnt + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==================================================================
    // assertions
    chk_reset_span:
        assert property ($fell(se0) && !line_oe_o[2] |-> se0_cnt >= RESET_CYCLES)
        else $error("reset signalling shorter than required");
    chk_resume_span:
        assert property ($fell(kst) |-> k_cnt >= RESUME_CYCLES)
        else $error("resume K shorter than required");
    chk_k_then_eop:
        assert property ($fell(kst) |-> se0)
        else $error("resume K not followed by end of packet");
    chk_eop_then_j:
        assert property ($fell(se0) && line_oe_o[2] |-> dplus_o[2] && !dminus_o[2])
        else $error("end of packet not closed by J");
    chk_no_fwd_signal:
        assert property ((se0 || kst)[*2] |-> !forward_en_o[2])
        else $error("traffic forwarded during reset or resume");
    chk_fn_susp_gate:
        assert property (function_suspend_o[*2] |-> !forward_en_o[1])
        else $error("suspended function still forwards");
    chk_fn_reset_pulse:
        assert property (function_reset_o |=> !function_reset_o)
        else $error("function reset longer than one cycle");
    chk_oc_power_off:
        assert property (overcurrent_i[*5] |-> port_power_o == 4'h0)
        else $error("power kept on during over-current");
    chk_unpowered_quiet:
        assert property ((!port_power_o[2])[*3] |-> !se0)
        else $error("reset driven on unpowered port");
    cover property ($fell(se0) && !line_oe_o[2]);
    cover property ($fell(kst));
    cover property (function_reset_o);
endmodule // uhdpc_checker
bind uhdpc_port_ctrl uhdpc_checker #(.RESET_CYCLES(RESET_CYCLES),
    .RESUME_CYCLES(RESUME_CYCLES)) uhdpc_checker_inst (.clk_i(clk_i),
    .rst_i(rst_i), .overcurrent_i(overcurrent_i), .dplus_o(dplus_o),
    .dminus_o(dminus_o), .line_oe_o(line_oe_o),
    .port_power_o(port_power_o), .forward_en_o(forward_en_o),
    .function_reset_o(function_reset_o),
    .function_suspend_o(function_suspend_o));
`default_nettype wire

//--- uhdpc_partner.sv
/* Downstream devices on external ports 2..5.
   Assumes host-side pull-downs: an absent or unpowered device reads 0. */
`timescale 1ns/1ns
`default_nettype none
module uhdpc_partner
(
    input  wire logic [5:2] attach_i,
    input  wire logic [5:2] slow_i,
    input  wire logic [5:2] power_i,
    input  wire logic [5:2] line_oe_i,
    input  wire logic [5:2] drv_dp_i,
    input  wire logic [5:2] drv_dm_i,
    output logic      [5:2] dplus_o,
    output logic      [5:2] dminus_o
);
    logic [5:2] present;
    assign present = attach_i & power_i;
    // full-speed idle pulls D+ high, low-speed idle pulls D- high
    assign dplus_o  = (line_oe_i & drv_dp_i) | (~line_oe_i & present & ~slow_i);
    assign dminus_o = (line_oe_i & drv_dm_i) | (~line_oe_i & present & slow_i);
endmodule // uhdpc_partner
`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for uhdpc_port_ctrl over AHB-Lite.
   Assumes zero-wait slave; shortened reset and resume counts. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
    import uhdpc_pkg::*;
    localparam int RST_C = 50;
    localparam int RES_C = 60;
    logic        clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, eof = 0;
    logic        idle = 0, oc = 0;
    logic [31:0] haddr = 0, hwdata = 0, rdata, hrdata;
    logic [1:0]  htrans = 0;
    logic [5:2]  attach = 4'hb, slow = 4'h2, dp, dm, dpo, dmo, oe, pwr;
    logic [5:1]  fwd;
    logic        hready, hresp, frst, fsusp, saw_frst = 0;
    int          err_count = 0, n_tests = 0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (frst) saw_frst <= 1'b1;
    uhdpc_port_ctrl #(.RESET_CYCLES(RST_C), .RESUME_CYCLES(RES_C))
    uhdpc_port_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .eof_sample_i(eof), .bus_idle_i(idle), .dplus_i(dp),
        .dminus_i(dm), .overcurrent_i(oc), .dplus_o(dpo), .dminus_o(dmo),
        .line_oe_o(oe), .port_power_o(pwr), .forward_en_o(fwd),
        .function_reset_o(frst), .function_suspend_o(fsusp));
    uhdpc_partner uhdpc_partner_inst (.attach_i(attach), .slow_i(slow),
        .power_i(pwr), .line_oe_i(oe), .drv_dp_i(dpo), .drv_dm_i(dmo),
        .dplus_o(dp), .dminus_o(dm));
    // ==================================================================
    // bus and stimulus tasks
    task automatic bus(input logic w, input logic [9:0] i,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        hwrite <= w;
        htrans <= 2'h2;
        haddr  <= {20'h0, i, 2'h0};
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rdata = hrdata;
    endtask
    task automatic stat(input logic [7:0] e);
        bus(1'b0, UHDPC_IDX_STATUS, 32'h0);
        `CHK(rdata[7:0], e)
    endtask
    // state changes one edge after the data phase, outputs one later
    task automatic cmd(input logic [2:0] c);
        bus(1'b1, UHDPC_IDX_COMMAND, {29'h0, c});
        repeat (3) @(posedge clk_i);
    endtask
    task automatic sel(input logic [7:0] s);
        bus(1'b1, UHDPC_IDX_SELECT, {24'h0, s});
    endtask
    task automatic eofp;
        eof <= 1'b1;
        @(posedge clk_i);
        eof <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic idl;
        idle <= 1'b1;
        @(posedge clk_i);
        idle <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // ==================================================================
    // scenarios
    task automatic t_regs;
        bus(1'b0, UHDPC_IDX_SELECT, 32'h0);
        `CHK(rdata[7:0], UHDPC_SELECT_RST)
        bus(1'b0, UHDPC_IDX_POWER, 32'h0);
        `CHK(rdata[5:2], UHDPC_POWER_RST)
        stat(UHDPC_STATUS_RST);
        bus(1'b1, UHDPC_IDX_STATUS, 32'hff);
        eofp;
        stat(8'h91);
        bus(1'b0, 10'h3ff, 32'h0);
        `CHK(rdata, 32'h0)
    endtask
    task automatic t_port1;
        cmd(UHDPC_CMD_ENABLE);
        eofp;
        stat(8'h91);
        idl;
        stat(8'h91);
        eofp;
        stat(8'h93);
        cmd(UHDPC_CMD_RESUME);
        idl;
        eofp;
        stat(8'h93);
        cmd(UHDPC_CMD_SUSPEND);
        idl;
        eofp;
        stat(8'h97);
        `CHK({fsusp, fwd[1]}, 2'b10)
        cmd(UHDPC_CMD_ENABLE);
        idl;
        eofp;
        stat(8'h97);
        cmd(UHDPC_CMD_RESUME);
        repeat (RES_C + 5) @(posedge clk_i);
        eofp;
        stat(8'h93);
        cmd(UHDPC_CMD_RESET);
        `CHK(saw_frst, 1'b1)
        eofp;
        bus(1'b0, UHDPC_IDX_STATUS, 32'h0);
        `CHK(rdata[3], 1'b1)
        repeat (RST_C) @(posedge clk_i);
        eofp;
        stat(8'h93);
    endtask
    task automatic t_ext;
        sel(8'h01);
        bus(1'b1, UHDPC_IDX_POWER, 32'h3c);
        repeat (4) @(posedge clk_i);
        eofp;
        eofp;
        stat(8'h91);
        cmd(UHDPC_CMD_RESET);
        `CHK({oe[2], dpo[2], dmo[2]}, 3'b100)
        eofp;
        bus(1'b0, UHDPC_IDX_STATUS, 32'h0);
        `CHK(rdata[3], 1'b1)
        repeat (RST_C) @(posedge clk_i);
        eofp;
        stat(8'h93);
        cmd(UHDPC_CMD_SUSPEND);
        idl;
        eofp;
        stat(8'h97);
        `CHK(fwd[2], 1'b0)
        cmd(UHDPC_CMD_RESUME);
        `CHK({oe[2], dpo[2], dmo[2]}, 3'b101)
        repeat (RES_C + 300) @(posedge clk_i);
        eofp;
        stat(8'h93);
        cmd(UHDPC_CMD_DISABLE);
        idl;
        eofp;
        stat(8'h91);
        sel(8'h02);
        stat(8'h71);
        sel(8'h03);
        stat(8'h10);
        cmd(UHDPC_CMD_RESET);
        `CHK(oe[4], 1'b0)
        sel(8'h04);
        stat(8'h91);
        sel(8'h01);
        oc <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHK(pwr, 4'h0)
        eofp;
        stat(8'h00);
    endtask
    task automatic end_of_test;
        $display("errors %0d of %0d checks", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test;
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_port1;
        t_ext;
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
